// [scs_pkg.sv]
// Constants, types and the state record of the system clock source selector.
// Assumes a 25 MHz housekeeping clock; all times below are turned into cycles of it.
`default_nettype none

package scs_pkg;

    // ------------------------------------------------------------
    // Clock rate
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;

    // ------------------------------------------------------------
    // Register word indices and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] CTRL_IDX          = 2'h0;
    localparam logic [1:0] STAT_IDX          = 2'h1;
    localparam int         CTRL_MULT_BIT     = 7;
    localparam int         CTRL_FREQ_LSB     = 3;
    localparam int         CTRL_RSVD_BIT     = 2;
    localparam int         CTRL_SCS_LSB      = 0;
    localparam int         STAT_MULT_RDY_BIT = 6;
    localparam int         STAT_HF_RDY_BIT   = 4;
    localparam int         STAT_LF_RDY_BIT   = 1;
    localparam int         STAT_HF_STB_BIT   = 0;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST       = 8'h38;
    localparam logic [3:0] FREQ_MULT_CODE = 4'hE;
    localparam logic [1:0] WAKE_EXT_EDGES = 2'h2;
    localparam logic [1:0] SWITCH_EDGES   = 2'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int HF_START_NS   = 2000;
    localparam int HF_START_CYC  = (HF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HF_SETTLE_NS  = 2000;
    localparam int HF_SETTLE_CYC = (HF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WARM_NS       = 2000;
    localparam int WARM_CYC      = (WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_LOCK_NS   = 2000000;
    localparam int PLL_LOCK_CYC  = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Oscillator indices into the sampled clock vector
    // ------------------------------------------------------------
    localparam int OSC_HF  = 0;
    localparam int OSC_LF  = 1;
    localparam int OSC_EXT = 2;

    typedef enum logic [1:0] {SRC_EXT, SRC_HF, SRC_MF, SRC_LF} scs_src_t;
    typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_START, ST_OLD_EDGE, ST_NEW_EDGE} scs_fsm_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic        wait_req;
        logic [31:0] rdata;
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  prev;
        scs_src_t    cur_src;
        scs_src_t    tgt_src;
        scs_fsm_t    fsm;
        logic [15:0] cnt;
        logic [1:0]  edges;
        logic        warm;
        logic        hf_en;
        logic [15:0] hf_cnt;
        logic        hf_rdy;
        logic        hf_stb;
        logic        lf_en;
        logic        lf_rdy;
        logic [15:0] pll_cnt;
        logic        pll_rdy;
        logic        pll_act;
        logic        clk_out;
        logic [3:0]  freq_act;
        logic        busy;
    } scs_state_t;

endpackage

`default_nettype wire

// [scs_top.sv]
// System clock source selector: control and status registers on Avalon-MM,
// oscillator enables, start-up timers and a glitch-free clock switch.
// Assumes the oscillator clocks arrive as pins, asynchronous to SYS_CLK.
//
// Contract
// - Select 00 uses configuration-word clock source
// - Select 1x uses internal frequency selection
// - Reset clears clock source select field
// - Hold off switch until new clock ready
// - Sleep wake onto internal waits warm-up; the code skips it while the multiplier is requested
// - Control bit 7 enables 4x multiplier
// - Bits 6..3 choose the internal frequency
// - Frequency select resets to 0111
// - Codes 1111..1000 come from high oscillator
// - Control bit 2 reads as zero
// - Status bit 6 shows multiplier ready
// - Status bit 4 shows high oscillator ready
// - Status bit 1 shows low oscillator ready
// - Status bit 0 shows high oscillator stable
// - Status bits 7,5,3,2 read zero, read-only
// - New oscillator: start, then await falling edge
// - Same oscillator change applies at once
// - Multiplier only for select 00, code 1110
`default_nettype none

module scs_top #(
    parameter int PLL_LOCK_CYC = scs_pkg::PLL_LOCK_CYC,
    parameter int WARM_CYC     = scs_pkg::WARM_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RSTN,
    input  wire logic [1:0]  AV_ADDRESS,
    input  wire logic        AV_READ,
    input  wire logic        AV_WRITE,
    input  wire logic [31:0] AV_WRITEDATA,
    input  wire logic [3:0]  AV_BYTEENABLE,
    output logic      [31:0] AV_READDATA,
    output logic             AV_WAITREQUEST,
    input  wire logic        CFG_INTERNAL,
    input  wire logic        SLEEP,
    input  wire logic        HF_OSC_CLK,
    input  wire logic        LF_OSC_CLK,
    input  wire logic        EXT_CLK,
    output logic             CLK_OUT,
    output logic             HF_OSC_EN,
    output logic             LF_OSC_EN,
    output logic             MULT_ACTIVE,
    output logic      [1:0]  ACTIVE_SRC,
    output logic      [3:0]  ACTIVE_FREQ_SEL,
    output logic             SWITCH_BUSY
);

    localparam int HF_CYC = scs_pkg::HF_START_CYC;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Source chosen by the select and frequency fields
    function automatic scs_pkg::scs_src_t src_of(input logic [7:0] c, input logic cfg_int);
        logic [3:0] f;
        f = c[scs_pkg::CTRL_FREQ_LSB +: 4];
        if (!c[scs_pkg::CTRL_SCS_LSB + 1] && !cfg_int) begin
            src_of = scs_pkg::SRC_EXT;
        end else if (f[3]) begin
            src_of = scs_pkg::SRC_HF;
        end else if (f[3:1] == 3'h0) begin
            src_of = scs_pkg::SRC_LF;
        end else begin
            src_of = scs_pkg::SRC_MF;
        end
    endfunction

    // Physical oscillator behind a source; mid path is a postscaler of the high one
    function automatic int osc_of(input scs_pkg::scs_src_t s);
        unique case (s)
            scs_pkg::SRC_EXT: osc_of = scs_pkg::OSC_EXT;
            scs_pkg::SRC_LF:  osc_of = scs_pkg::OSC_LF;
            scs_pkg::SRC_HF,
            scs_pkg::SRC_MF:  osc_of = scs_pkg::OSC_HF;
        endcase
    endfunction

    scs_pkg::scs_state_t s_r;
    scs_pkg::scs_state_t s_nxt;
    scs_pkg::scs_src_t   tgt_w;
    logic                pll_req;
    logic [2:0]          fall;
    logic                new_rdy;
    logic                warm_need;
    logic [1:0]          need_edges;
    logic [7:0]          stat_w;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        tgt_w = src_of(s_r.ctrl, CFG_INTERNAL);
        // Multiplier path exists only under config-word source at 8 MHz
        pll_req = s_r.ctrl[scs_pkg::CTRL_MULT_BIT] && CFG_INTERNAL
               && (s_r.ctrl[scs_pkg::CTRL_SCS_LSB +: 2] == 2'h0)
               && (s_r.ctrl[scs_pkg::CTRL_FREQ_LSB +: 4] == scs_pkg::FREQ_MULT_CODE);
        fall = s_r.prev & ~s_r.sync2;
        stat_w = 8'h00;
        stat_w[scs_pkg::STAT_MULT_RDY_BIT] = s_r.pll_rdy;
        stat_w[scs_pkg::STAT_HF_RDY_BIT] = s_r.hf_rdy;
        stat_w[scs_pkg::STAT_LF_RDY_BIT] = s_r.lf_rdy;
        stat_w[scs_pkg::STAT_HF_STB_BIT] = s_r.hf_stb;

        // Pin sampling; the first stage is never looked at
        s_nxt.sync1 = {EXT_CLK, LF_OSC_CLK, HF_OSC_CLK};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;

        // Bus slave: one wait cycle, then a single-cycle answer
        s_nxt.wait_req = 1'b1;
        if ((AV_READ || AV_WRITE) && s_r.wait_req) begin
            s_nxt.wait_req = 1'b0;
            s_nxt.rdata = 32'h0000_0000;
            if (AV_READ && AV_ADDRESS == scs_pkg::CTRL_IDX) begin
                s_nxt.rdata[7:0] = s_r.ctrl;
            end else if (AV_READ && AV_ADDRESS == scs_pkg::STAT_IDX) begin
                s_nxt.rdata[7:0] = stat_w;
            end
            // Status index is not writable at all
            if (AV_WRITE && AV_ADDRESS == scs_pkg::CTRL_IDX && AV_BYTEENABLE[0]) begin
                s_nxt.ctrl = AV_WRITEDATA[7:0];
                s_nxt.ctrl[scs_pkg::CTRL_RSVD_BIT] = 1'b0;
            end
        end

        // High oscillator: start-up, then settle to stable
        s_nxt.hf_en = !SLEEP && (pll_req || osc_of(s_r.cur_src) == scs_pkg::OSC_HF
                   || (s_r.busy && osc_of(s_r.tgt_src) == scs_pkg::OSC_HF));
        // Ready and stable fall with the enable, so status never outlives the oscillator
        if (!s_r.hf_en || !s_nxt.hf_en) begin
            s_nxt.hf_cnt = 16'h0000;
            s_nxt.hf_rdy = 1'b0;
            s_nxt.hf_stb = 1'b0;
        end else if (!s_r.hf_stb) begin
            s_nxt.hf_cnt = s_r.hf_cnt + 16'h0001;
            if (s_r.hf_cnt == 16'(scs_pkg::HF_START_CYC - 1)) begin
                s_nxt.hf_rdy = 1'b1;
            end
            if (s_r.hf_cnt == 16'(scs_pkg::HF_START_CYC + scs_pkg::HF_SETTLE_CYC - 1)) begin
                s_nxt.hf_stb = 1'b1;
            end
        end

        // Low oscillator: ready at its first falling edge once enabled
        s_nxt.lf_en = !SLEEP && (osc_of(s_r.cur_src) == scs_pkg::OSC_LF
                   || (s_r.busy && osc_of(s_r.tgt_src) == scs_pkg::OSC_LF));
        if (!s_r.lf_en) begin
            s_nxt.lf_rdy = 1'b0;
        end else if (fall[scs_pkg::OSC_LF]) begin
            s_nxt.lf_rdy = 1'b1;
        end

        // Multiplier lock timer
        if (!pll_req || !s_r.hf_rdy) begin
            s_nxt.pll_cnt = 16'h0000;
            s_nxt.pll_rdy = 1'b0;
        end else if (!s_r.pll_rdy) begin
            s_nxt.pll_cnt = s_r.pll_cnt + 16'h0001;
            if (s_r.pll_cnt == 16'(PLL_LOCK_CYC - 1)) begin
                s_nxt.pll_rdy = 1'b1;
            end
        end
        s_nxt.pll_act = pll_req && s_r.pll_rdy;

        // Switch sequencer
        unique case (osc_of(s_r.tgt_src))
            scs_pkg::OSC_HF: new_rdy = s_r.hf_rdy;
            scs_pkg::OSC_LF: new_rdy = s_r.lf_rdy;
            default:         new_rdy = 1'b1;
        endcase
        warm_need = s_r.warm && s_r.tgt_src != scs_pkg::SRC_EXT && !pll_req;
        need_edges = (s_r.warm && s_r.tgt_src == scs_pkg::SRC_EXT) ?
                     scs_pkg::WAKE_EXT_EDGES : scs_pkg::SWITCH_EDGES;
        unique case (s_r.fsm)
            scs_pkg::ST_RUN: begin
                s_nxt.clk_out = s_r.sync2[osc_of(s_r.cur_src)];
                if (SLEEP) begin
                    s_nxt.fsm = scs_pkg::ST_SLEEP;
                    s_nxt.clk_out = 1'b0;
                end else if (osc_of(tgt_w) == osc_of(s_r.cur_src)) begin
                    // Same oscillator: postscaler retap needs no start-up
                    s_nxt.cur_src = tgt_w;
                    s_nxt.freq_act = s_r.ctrl[scs_pkg::CTRL_FREQ_LSB +: 4];
                end else begin
                    s_nxt.fsm = scs_pkg::ST_START;
                    s_nxt.tgt_src = tgt_w;
                    s_nxt.cnt = 16'h0000;
                end
            end
            scs_pkg::ST_SLEEP: begin
                s_nxt.clk_out = 1'b0;
                if (!SLEEP) begin
                    s_nxt.fsm = scs_pkg::ST_START;
                    s_nxt.tgt_src = tgt_w;
                    s_nxt.warm = 1'b1;
                    s_nxt.cnt = 16'h0000;
                end
            end
            scs_pkg::ST_START: begin
                // Output follows the old clock while the new one starts, and stays low on wake from sleep
                s_nxt.clk_out = s_r.warm ? 1'b0 : s_r.sync2[osc_of(s_r.cur_src)];
                if (warm_need && s_r.cnt != 16'(WARM_CYC)) begin
                    s_nxt.cnt = s_r.cnt + 16'h0001;
                end else if (new_rdy) begin
                    s_nxt.edges = 2'h0;
                    s_nxt.fsm = s_r.warm ? scs_pkg::ST_NEW_EDGE : scs_pkg::ST_OLD_EDGE;
                end
            end
            scs_pkg::ST_OLD_EDGE: begin
                // Leave the old clock only on its falling edge, so no runt high phase
                s_nxt.clk_out = s_r.sync2[osc_of(s_r.cur_src)];
                if (fall[osc_of(s_r.cur_src)]) begin
                    s_nxt.fsm = scs_pkg::ST_NEW_EDGE;
                    s_nxt.clk_out = 1'b0;
                end
            end
            scs_pkg::ST_NEW_EDGE: begin
                s_nxt.clk_out = 1'b0;
                if (fall[osc_of(s_r.tgt_src)]) begin
                    s_nxt.edges = s_r.edges + 2'h1;
                    if (s_r.edges + 2'h1 == need_edges) begin
                        s_nxt.fsm = scs_pkg::ST_RUN;
                        s_nxt.cur_src = s_r.tgt_src;
                        s_nxt.freq_act = s_r.ctrl[scs_pkg::CTRL_FREQ_LSB +: 4];
                        s_nxt.warm = 1'b0;
                    end
                end
            end
        endcase
        s_nxt.busy = s_nxt.fsm != scs_pkg::ST_RUN;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset leaves select at 00 and starts on the external source, whatever the config word
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_r <= '0;
            s_r.ctrl <= scs_pkg::CTRL_RST;
            s_r.wait_req <= 1'b1;
            s_r.cur_src <= scs_pkg::SRC_EXT;
            s_r.tgt_src <= scs_pkg::SRC_EXT;
            s_r.fsm <= scs_pkg::ST_START;
            s_r.freq_act <= scs_pkg::CTRL_RST[scs_pkg::CTRL_FREQ_LSB +: 4];
            s_r.busy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign AV_READDATA     = s_r.rdata;
    assign AV_WAITREQUEST  = s_r.wait_req;
    assign CLK_OUT         = s_r.clk_out;
    assign HF_OSC_EN       = s_r.hf_en;
    assign LF_OSC_EN       = s_r.lf_en;
    assign MULT_ACTIVE     = s_r.pll_act;
    assign ACTIVE_SRC      = s_r.cur_src;
    assign ACTIVE_FREQ_SEL = s_r.freq_act;
    assign SWITCH_BUSY     = s_r.busy;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_values: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        $rose(RSTN) |-> s_r.ctrl == scs_pkg::CTRL_RST)
        else $error("control register not at reset value after reset");
    a_ctrl_bit2: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (!AV_WAITREQUEST && AV_READ && AV_ADDRESS == scs_pkg::CTRL_IDX)
        |-> AV_READDATA[2] == 1'b0 && AV_READDATA[7:0] == s_r.ctrl)
        else $error("control readback wrong");
    a_stat_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (!AV_WAITREQUEST && AV_READ && AV_ADDRESS == scs_pkg::STAT_IDX)
        |-> AV_READDATA[7] == 1'b0 && AV_READDATA[5] == 1'b0 && AV_READDATA[3:2] == 2'h0)
        else $error("unimplemented status bits not zero");
    a_hf_start: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        $rose(s_r.hf_rdy) |-> $past(s_r.hf_en, HF_CYC) && $past(s_r.hf_en))
        else $error("high oscillator ready too early");
    a_hf_stable: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        s_r.hf_stb |-> s_r.hf_rdy && s_r.hf_en)
        else $error("stable without ready");
    a_lf_ready: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        $rose(s_r.lf_rdy) |-> $past(fall[scs_pkg::OSC_LF]) && $past(s_r.lf_en))
        else $error("low oscillator ready without a cycle");
    a_pll_lock: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        $rose(s_r.pll_rdy) |-> $past(s_r.pll_cnt) == 16'(PLL_LOCK_CYC - 1))
        else $error("multiplier ready before lock time");
    a_pll_gate: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        !pll_req |=> !MULT_ACTIVE ##1 !MULT_ACTIVE)
        else $error("multiplier active outside its setting");
    a_same_osc: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (s_r.fsm == scs_pkg::ST_RUN && !SLEEP && tgt_w != s_r.cur_src)
        |=> s_r.cur_src == $past(tgt_w) || s_r.fsm == scs_pkg::ST_START)
        else $error("run state did not follow selection");
    a_switch_low: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (s_r.fsm == scs_pkg::ST_NEW_EDGE) |=> !CLK_OUT || s_r.fsm == scs_pkg::ST_RUN)
        else $error("clock output high during switch");
    a_wait_pulse: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        !AV_WAITREQUEST |=> AV_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");

endmodule

`default_nettype wire

// [scs_top_test.sv]
// Self-checking testbench for the system clock source selector.
// Assumes scs_pkg and scs_top are compiled first; the bench plays bus master
// and drives the oscillator pins, SLEEP and the configuration-word input.
`default_nettype none

module scs_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------
    localparam int PLL_CYC = 20;
    localparam int WRM_CYC = 4;

    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
    } scs_note_t;

    logic        SYS_CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic [1:0]  AV_ADDRESS = 2'h0;
    logic        AV_READ = 1'b0;
    logic        AV_WRITE = 1'b0;
    logic [31:0] AV_WRITEDATA = 32'h0;
    logic [3:0]  AV_BYTEENABLE = 4'hF;
    logic [31:0] AV_READDATA;
    logic        AV_WAITREQUEST;
    logic        CFG_INTERNAL = 1'b0;
    logic        SLEEP = 1'b0;
    logic        HF_OSC_CLK = 1'b0;
    logic        LF_OSC_CLK = 1'b0;
    logic        EXT_CLK = 1'b0;
    logic        CLK_OUT;
    logic        HF_OSC_EN;
    logic        LF_OSC_EN;
    logic        MULT_ACTIVE;
    logic [1:0]  ACTIVE_SRC;
    logic [3:0]  ACTIVE_FREQ_SEL;
    logic        SWITCH_BUSY;
    logic [7:0]  ph = 8'h0;
    scs_note_t   exp_q[$];
    int          n_fail = 0;
    int          comparisons = 0;

    scs_top #(.PLL_LOCK_CYC(PLL_CYC), .WARM_CYC(WRM_CYC)) uut (
        .SYS_CLK(SYS_CLK), .RSTN(RSTN), .AV_ADDRESS(AV_ADDRESS), .AV_READ(AV_READ),
        .AV_WRITE(AV_WRITE), .AV_WRITEDATA(AV_WRITEDATA), .AV_BYTEENABLE(AV_BYTEENABLE),
        .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST),
        .CFG_INTERNAL(CFG_INTERNAL), .SLEEP(SLEEP), .HF_OSC_CLK(HF_OSC_CLK),
        .LF_OSC_CLK(LF_OSC_CLK), .EXT_CLK(EXT_CLK), .CLK_OUT(CLK_OUT),
        .HF_OSC_EN(HF_OSC_EN), .LF_OSC_EN(LF_OSC_EN), .MULT_ACTIVE(MULT_ACTIVE),
        .ACTIVE_SRC(ACTIVE_SRC), .ACTIVE_FREQ_SEL(ACTIVE_FREQ_SEL),
        .SWITCH_BUSY(SWITCH_BUSY));

    // 25 MHz system clock
    always #20 SYS_CLK = ~SYS_CLK;

    // Oscillator pins at unlike rates so every synchroniser sees real edges
    always @(posedge SYS_CLK) begin
        ph         <= ph + 8'h1;
        HF_OSC_CLK <= ~HF_OSC_CLK;
        LF_OSC_CLK <= ph[2];
        EXT_CLK    <= ph[1];
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Masked compare; the mask keeps out bits whose level is not fixed yet
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input logic [31:0] m, input string what);
        comparisons++;
        if ((seen & m) !== (exp & m)) begin
            n_fail++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen & m, exp & m);
        end
    endtask

    // One Avalon cycle; idle edge afterwards so the next request is a fresh one
    task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int i;
        AV_ADDRESS    <= a;
        AV_WRITEDATA  <= d;
        AV_BYTEENABLE <= be;
        if (wr) begin
            AV_WRITE <= 1'b1;
        end else begin
            AV_READ <= 1'b1;
        end
        for (i = 0; i < 50; i++) begin
            @(posedge SYS_CLK);
            if (AV_WAITREQUEST === 1'b0) break;
        end
        if (i == 50) begin
            n_fail++;
            $display("[FAIL] %0t bus answer missing", $time);
            results();
        end
        AV_READ  <= 1'b0;
        AV_WRITE <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'h1);
    endtask

    // Note the expectation first; the monitor settles it at the answer edge
    task automatic rd(input logic [1:0] a, input logic [7:0] d, input logic [7:0] m);
        exp_q.push_back('{d: {24'h0, d}, m: {24'hFFFFFF, m}});
        bus(1'b0, a, 32'h0, 4'hF);
    endtask

    // Bounded wait for the clock switch to finish; busy must stay low for two
    // edges, since a switch that ends under a stale selection drops it for one
    task automatic wait_idle();
        int i;
        int q;
        q = 0;
        repeat (3) @(posedge SYS_CLK);
        for (i = 0; i < 3000 && q < 2; i++) begin
            @(posedge SYS_CLK);
            q = (SWITCH_BUSY === 1'b0) ? q + 1 : 0;
        end
        if (q < 2) begin
            n_fail++;
            $display("[FAIL] %0t switch never finished", $time);
            results();
        end
    endtask

    function automatic logic [1:0] src_of(input logic [3:0] c);
        if (c >= 4'h8) return 2'(scs_pkg::SRC_HF);
        if (c >= 4'h2) return 2'(scs_pkg::SRC_MF);
        return 2'(scs_pkg::SRC_LF);
    endfunction

    // ------------------------------------------------------------
    // Read-data monitor
    // ------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (RSTN === 1'b1 && AV_READ === 1'b1 && AV_WAITREQUEST === 1'b0) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("[FAIL] %0t read answer without request", $time);
            end else begin
                scs_note_t e;
                e = exp_q.pop_front();
                check(AV_READDATA, e.d, e.m, "read data");
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [3:0]  c;
        void'($urandom(65));
        repeat (4) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        @(posedge SYS_CLK);
        rd(scs_pkg::CTRL_IDX, 8'h38, 8'hFF);
        rd(scs_pkg::STAT_IDX, 8'h00, 8'hAC);
        // Random control patterns; bit 2 never sticks
        for (int k = 0; k < 6; k++) begin
            d = $urandom;
            wr(scs_pkg::CTRL_IDX, d[7:0]);
            rd(scs_pkg::CTRL_IDX, d[7:0] & 8'hFB, 8'hFF);
            bus(1'b1, scs_pkg::CTRL_IDX, ~d, 4'hE);
            rd(scs_pkg::CTRL_IDX, d[7:0] & 8'hFB, 8'hFF);
        end
        wr(scs_pkg::STAT_IDX, 8'hFF);
        rd(scs_pkg::STAT_IDX, 8'h00, 8'hAC);
        wr(2'h2, 8'h55);
        rd(2'h2, 8'h00, 8'hFF);
        rd(2'h3, 8'h00, 8'hFF);
        wait_idle();
        // Walk every frequency code on the internal block, high to low
        for (int k = 15; k >= 0; k--) begin
            c = 4'(k);
            wr(scs_pkg::CTRL_IDX, {1'b0, c, 3'b010});
            wait_idle();
            check({30'h0, ACTIVE_SRC}, {30'h0, src_of(c)}, 32'h3, "source");
            check({28'h0, ACTIVE_FREQ_SEL}, {28'h0, c}, 32'hF, "freq code");
            if (k == 15) begin
                rd(scs_pkg::STAT_IDX, 8'h10, 8'hBC);
                repeat (scs_pkg::HF_SETTLE_CYC + 5) @(posedge SYS_CLK);
                rd(scs_pkg::STAT_IDX, 8'h11, 8'hBD);
            end
        end
        rd(scs_pkg::STAT_IDX, 8'h02, 8'hAE);
        check({30'h0, HF_OSC_EN, LF_OSC_EN}, 32'h1, 32'h3, "osc enables on low");
        // Sleep and wake back onto the low oscillator
        SLEEP <= 1'b1;
        repeat (20) @(posedge SYS_CLK);
        check({31'h0, CLK_OUT}, 32'h0, 32'h1, "clock in sleep");
        check({30'h0, HF_OSC_EN, LF_OSC_EN}, 32'h0, 32'h3, "osc enables in sleep");
        SLEEP <= 1'b0;
        wait_idle();
        check({30'h0, ACTIVE_SRC}, {30'h0, 2'(scs_pkg::SRC_LF)}, 32'h3, "wake source");
        // Multiplier on select 00 with the 8 MHz code, then refused under select 1x
        CFG_INTERNAL <= 1'b1;
        wr(scs_pkg::CTRL_IDX, 8'hF0);
        wait_idle();
        repeat (scs_pkg::HF_START_CYC + PLL_CYC + 10) @(posedge SYS_CLK);
        rd(scs_pkg::STAT_IDX, 8'h50, 8'hFC);
        check({31'h0, MULT_ACTIVE}, 32'h1, 32'h1, "multiplier on");
        wr(scs_pkg::CTRL_IDX, 8'hF2);
        wait_idle();
        check({31'h0, MULT_ACTIVE}, 32'h0, 32'h1, "multiplier under 1x");
        // Select 00 with an external configuration source
        CFG_INTERNAL <= 1'b0;
        wr(scs_pkg::CTRL_IDX, 8'h38);
        wait_idle();
        check({30'h0, ACTIVE_SRC}, {30'h0, 2'(scs_pkg::SRC_EXT)}, 32'h3, "cfg source");
        // Reset in mid-run restores the control defaults
        wr(scs_pkg::CTRL_IDX, 8'hFA);
        RSTN <= 1'b0;
        repeat (4) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        @(posedge SYS_CLK);
        rd(scs_pkg::CTRL_IDX, 8'h38, 8'hFF);
        wait_idle();
        results();
    end
endmodule

`default_nettype wire
